/* File: src/trc_pkg.sv */
// Shared constants and types of the threshold relay controller
package trc_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned DELAY_STEP_MS = 100;
  localparam int unsigned DELAY_STEP_CYCLES = CLK_HZ / 1000 * DELAY_STEP_MS;
  // Six seconds is one tenth of a minute
  localparam int unsigned STEPS_PER_MINUTE_STEP = 60;

  // ----------------------------------------------------------------
  // Ranges
  // ----------------------------------------------------------------
  localparam logic signed [15:0] THRESHOLD_MIN = -16'sd999;
  localparam logic signed [15:0] THRESHOLD_MAX = 16'sd9999;
  localparam logic [9:0] HALF_WIDTH_MAX = 10'h3e7;
  localparam logic [9:0] DELAY_MAX = 10'h3e7;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] RELAY_STRIDE = 8'h20;
  localparam logic [7:0] OFS_PRIMARY = 8'h00;
  localparam logic [7:0] OFS_SECONDARY = 8'h04;
  localparam logic [7:0] OFS_HALF_WIDTH = 8'h08;
  localparam logic [7:0] OFS_RELAY_CFG = 8'h0c;
  localparam logic [7:0] OFS_DELAYS = 8'h10;
  localparam logic [7:0] ADDR_BUZZER = 8'h80;
  localparam logic [7:0] ADDR_LINK_TIMEOUT = 8'h84;
  localparam logic [7:0] ADDR_STATUS = 8'h88;

  // Relay configuration fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_UNIT_MIN_BIT = 3;
  localparam int CFG_REACT_LSB = 4;
  localparam int CFG_PEAK_BIT = 6;
  // Delay register fields
  localparam int DLY_ON_LSB = 0;
  localparam int DLY_OFF_LSB = 16;
  // Buzzer register fields
  localparam int BUZ_ALARM_BIT = 0;
  localparam int BUZ_RELAY_LSB = 1;
  // Status register fields
  localparam int ST_RELAY_LSB = 0;
  localparam int ST_BUZZER_BIT = 4;
  localparam int ST_LINK_LOST_BIT = 5;
  localparam int ST_RANGE_BIT = 6;
  localparam int ST_CRIT_LSB = 8;

  // Reset values
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [15:0] LINK_TIMEOUT_RESET = 16'h0000;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    TRC_RELAY_DISABLED,
    TRC_ABOVE_ON,
    TRC_ABOVE_OFF,
    TRC_WINDOW_INSIDE,
    TRC_WINDOW_OUTSIDE,
    TRC_BUS_COMMANDED
  } trc_mode_e;

  typedef enum logic [1:0] {
    TRC_HOLD_PRESENT_STATE,
    TRC_FORCE_ON,
    TRC_FORCE_OFF
  } trc_reaction_e;

endpackage

/* File: src/trc_top.sv */
// Threshold relay controller with AXI4-Lite register access
`timescale 1ns/100ps

// Operation
// - Signed primary threshold -999..9999, band midpoint
// - Secondary threshold used only in windows
// - Half-width 0..999 applied both sides
// - Disabled relay stays off unless forced
// - Normal: on above upper, off below lower
// - Inverted: off above upper, on below
// - Inside window on, thresholds ordered by value
// - Outside window on, off inside
// - Bus-commanded relay follows link commands
// - LED lit exactly while relay closed
// - Bus-commanded state not kept over reset
// - Turn-on delay 0..99.9 in tenths
// - Turn-off delay 0..99.9 in tenths
// - Short border crossing keeps relay state
// - Per-relay delay unit seconds or minutes
// - Critical reaction: hold, force on, off
// - Out-of-range measurement is critical
// - Link silence beyond timeout is critical
// - Force-on works even when disabled
// - Buzzer on critical or enabled relay activation
// - Without relays, alarm enable sounds buzzer
// - Button press silences buzzer unless a new event sounds it in that cycle
// - Independent settings per fitted relay only
// - Compare present value or held peak
module trc_top
  import trc_pkg::*;
#(
  parameter int NUM_RELAYS = 4,
  parameter logic [3:0] RELAYS_FITTED = 4'hf,
  parameter int unsigned STEP_CYCLES = DELAY_STEP_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Measurement front end
  input wire logic signed [15:0] meas_value,
  input wire logic signed [15:0] peak_value,
  input wire logic peak_active,
  input wire logic meas_out_of_range,
  // Serial link events
  input wire logic link_frame_strobe,
  input wire logic link_relay_we,
  input wire logic [3:0] link_relay_data,
  // Front panel
  input wire logic button_press,
  // Relay, LED and buzzer drive
  output logic [3:0] relay_out,
  output logic [3:0] led_out,
  output logic buzzer_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] trc_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic signed [15:0] trc_clamp_thr(input logic signed [15:0] v);
    if (v < THRESHOLD_MIN) begin
      return THRESHOLD_MIN;
    end else if (v > THRESHOLD_MAX) begin
      return THRESHOLD_MAX;
    end
    return v;
  endfunction

  function automatic logic [9:0] trc_clamp_10(input logic [15:0] v, input logic [9:0] lim);
    if (v > {6'h00, lim}) begin
      return lim;
    end
    return v[9:0];
  endfunction

  // Returns {decided, level}; decided low means the value sits in a band
  function automatic logic [1:0] trc_decide(input trc_mode_e mode, input logic signed [16:0] v,
                                            input logic signed [16:0] p,
                                            input logic signed [16:0] s,
                                            input logic signed [16:0] h);
    logic signed [16:0] lo;
    logic signed [16:0] hi;
    logic in_win;
    logic out_win;
    lo = (p < s) ? p : s;
    hi = (p < s) ? s : p;
    in_win = (v > lo + h) && (v < hi - h);
    out_win = (v > hi + h) || (v < lo - h);
    unique case (mode)
      TRC_ABOVE_ON: begin
        return (v > p + h) ? 2'b11 : ((v < p - h) ? 2'b10 : 2'b00);
      end
      TRC_ABOVE_OFF: begin
        return (v > p + h) ? 2'b10 : ((v < p - h) ? 2'b11 : 2'b00);
      end
      TRC_WINDOW_INSIDE: begin
        return in_win ? 2'b11 : (out_win ? 2'b10 : 2'b00);
      end
      TRC_WINDOW_OUTSIDE: begin
        return out_win ? 2'b11 : (in_win ? 2'b10 : 2'b00);
      end
      default: begin
        return 2'b10;
      end
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Configuration storage
  // ----------------------------------------------------------------
  logic signed [15:0] primary_threshold_reg [4];
  logic signed [15:0] secondary_threshold_reg [4];
  logic [9:0] band_half_width_reg [4];
  logic [7:0] relay_cfg_reg [4];
  logic [9:0] turn_on_delay_reg [4];
  logic [9:0] turn_off_delay_reg [4];
  logic [4:0] buzzer_settings_reg;
  logic [15:0] link_silence_timeout_reg;
  logic [3:0] bus_cmd_reg;
  logic [3:0] state_reg;
  logic [3:0] crit_reg;
  logic link_lost_reg;
  logic buzzer_reg;

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic aw_have_reg;
  logic w_have_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic aw_take;
  logic w_take;
  logic do_write;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic aw_have_next;
  logic w_have_next;
  logic bvalid_next;
  logic [2:0] wr_idx;
  logic [7:0] wr_ofs;
  logic wr_relay_ok;
  logic wr_ok;
  logic [31:0] dly_word;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign do_write = (aw_have_reg | aw_take) & (w_have_reg | w_take);
  assign wr_addr = aw_have_reg ? aw_addr_reg : s_axi_awaddr;
  assign wr_data = w_have_reg ? w_data_reg : s_axi_wdata;
  assign wr_strb = w_have_reg ? w_strb_reg : s_axi_wstrb;
  assign aw_have_next = (aw_have_reg | aw_take) & ~do_write;
  assign w_have_next = (w_have_reg | w_take) & ~do_write;
  assign bvalid_next = do_write | (s_axi_bvalid & ~s_axi_bready);
  assign wr_idx = wr_addr[7:5];
  assign wr_ofs = wr_addr & (RELAY_STRIDE - 8'h01);
  // settings of relays not fitted are unavailable
  assign wr_relay_ok = (wr_idx < 3'(NUM_RELAYS)) && RELAYS_FITTED[wr_idx[1:0]]
                       && (wr_ofs <= OFS_DELAYS) && (wr_ofs[1:0] == 2'b00);
  assign wr_ok = wr_relay_ok || (wr_addr == ADDR_BUZZER) || (wr_addr == ADDR_LINK_TIMEOUT)
                 || (wr_addr == ADDR_STATUS);
  assign dly_word = trc_merge({6'h00, turn_off_delay_reg[wr_idx[1:0]], 6'h00,
    turn_on_delay_reg[wr_idx[1:0]]}, wr_data, wr_strb);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      if (aw_take) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      s_axi_awready <= ~aw_have_next & ~bvalid_next;
      s_axi_wready <= ~w_have_next & ~bvalid_next;
      s_axi_bvalid <= bvalid_next;
      if (do_write) begin
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Register writes; a write lands on the same edge that accepts its second half
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        primary_threshold_reg[i] <= 16'sh0000;
        secondary_threshold_reg[i] <= 16'sh0000;
        band_half_width_reg[i] <= 10'h000;
        relay_cfg_reg[i] <= CFG_RESET;
        turn_on_delay_reg[i] <= 10'h000;
        turn_off_delay_reg[i] <= 10'h000;
      end
      buzzer_settings_reg <= 5'h00;
      link_silence_timeout_reg <= LINK_TIMEOUT_RESET;
    end else if (do_write) begin
      if (wr_relay_ok) begin
        unique case (wr_ofs)
          OFS_PRIMARY: begin
            primary_threshold_reg[wr_idx[1:0]] <= trc_clamp_thr(16'(trc_merge(
              32'(primary_threshold_reg[wr_idx[1:0]]), wr_data, wr_strb)));
          end
          OFS_SECONDARY: begin
            secondary_threshold_reg[wr_idx[1:0]] <= trc_clamp_thr(16'(trc_merge(
              32'(secondary_threshold_reg[wr_idx[1:0]]), wr_data, wr_strb)));
          end
          OFS_HALF_WIDTH: begin
            band_half_width_reg[wr_idx[1:0]] <= trc_clamp_10(16'(trc_merge(
              {22'h000000, band_half_width_reg[wr_idx[1:0]]}, wr_data, wr_strb)),
              HALF_WIDTH_MAX);
          end
          OFS_RELAY_CFG: begin
            relay_cfg_reg[wr_idx[1:0]] <= 8'(trc_merge({24'h000000, relay_cfg_reg[wr_idx[1:0]]},
                                                       wr_data, wr_strb));
          end
          // delays in tenths, at most 99.9
          default: begin
            turn_on_delay_reg[wr_idx[1:0]] <= trc_clamp_10(dly_word[DLY_ON_LSB +: 16],
              DELAY_MAX);
            turn_off_delay_reg[wr_idx[1:0]] <= trc_clamp_10(dly_word[DLY_OFF_LSB +: 16],
              DELAY_MAX);
          end
        endcase
      end else if (wr_addr == ADDR_BUZZER) begin
        buzzer_settings_reg <= 5'(trc_merge({27'h0000000, buzzer_settings_reg}, wr_data,
                                            wr_strb));
      end else if (wr_addr == ADDR_LINK_TIMEOUT) begin
        link_silence_timeout_reg <= 16'(trc_merge({16'h0000, link_silence_timeout_reg},
                                                  wr_data, wr_strb));
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  logic ar_take;
  logic rvalid_next;
  logic [2:0] rd_idx;
  logic [7:0] rd_ofs;
  logic rd_relay_ok;

  assign ar_take = s_axi_arvalid & s_axi_arready;
  assign rvalid_next = ar_take | (s_axi_rvalid & ~s_axi_rready);
  assign rd_idx = s_axi_araddr[7:5];
  assign rd_ofs = s_axi_araddr & (RELAY_STRIDE - 8'h01);
  assign rd_relay_ok = (rd_idx < 3'(NUM_RELAYS)) && RELAYS_FITTED[rd_idx[1:0]]
                       && (rd_ofs <= OFS_DELAYS) && (rd_ofs[1:0] == 2'b00);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_next;
      s_axi_rvalid <= rvalid_next;
      if (ar_take) begin
        s_axi_rresp <= RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        if (rd_relay_ok) begin
          unique case (rd_ofs)
            OFS_PRIMARY: s_axi_rdata <= 32'(primary_threshold_reg[rd_idx[1:0]]);
            OFS_SECONDARY: s_axi_rdata <= 32'(secondary_threshold_reg[rd_idx[1:0]]);
            OFS_HALF_WIDTH: s_axi_rdata <= {22'h000000, band_half_width_reg[rd_idx[1:0]]};
            OFS_RELAY_CFG: s_axi_rdata <= {24'h000000, relay_cfg_reg[rd_idx[1:0]]};
            default: begin
              s_axi_rdata <= {6'h00, turn_off_delay_reg[rd_idx[1:0]],
                              6'h00, turn_on_delay_reg[rd_idx[1:0]]};
            end
          endcase
        end else if (s_axi_araddr == ADDR_BUZZER) begin
          s_axi_rdata <= {27'h0000000, buzzer_settings_reg};
        end else if (s_axi_araddr == ADDR_LINK_TIMEOUT) begin
          s_axi_rdata <= {16'h0000, link_silence_timeout_reg};
        end else if (s_axi_araddr == ADDR_STATUS) begin
          s_axi_rdata <= {20'h00000, crit_reg, 1'b0, meas_out_of_range, link_lost_reg,
                          buzzer_reg, state_reg};
        end else begin
          s_axi_rresp <= RESP_SLVERR;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Time base and link supervision
  // ----------------------------------------------------------------
  logic [31:0] prescale_reg;
  logic [5:0] minute_div_reg;
  logic step_tick_reg;
  logic minute_tick_reg;
  logic [15:0] silence_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prescale_reg <= 32'h0000_0000;
      minute_div_reg <= 6'h00;
      step_tick_reg <= 1'b0;
      minute_tick_reg <= 1'b0;
    end else begin
      step_tick_reg <= 1'b0;
      minute_tick_reg <= 1'b0;
      if (prescale_reg >= 32'(STEP_CYCLES - 1)) begin
        prescale_reg <= 32'h0000_0000;
        step_tick_reg <= 1'b1;
        if (minute_div_reg >= 6'(STEPS_PER_MINUTE_STEP - 1)) begin
          minute_div_reg <= 6'h00;
          minute_tick_reg <= 1'b1;
        end else begin
          minute_div_reg <= minute_div_reg + 6'h01;
        end
      end else begin
        prescale_reg <= prescale_reg + 32'h0000_0001;
      end
    end
  end

  // Timeout of zero turns link supervision off
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      silence_reg <= 16'h0000;
      link_lost_reg <= 1'b0;
    end else begin
      if (link_frame_strobe) begin
        silence_reg <= 16'h0000;
      end else if (step_tick_reg && silence_reg != 16'hffff) begin
        silence_reg <= silence_reg + 16'h0001;
      end
      link_lost_reg <= ~link_frame_strobe && (link_silence_timeout_reg != 16'h0000)
                       && (silence_reg >= link_silence_timeout_reg);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_cmd_reg <= 4'h0;
    end else if (link_relay_we) begin
      bus_cmd_reg <= link_relay_data;
    end
  end

  // ----------------------------------------------------------------
  // Per-relay decision
  // ----------------------------------------------------------------
  logic [3:0] state_next;
  logic [3:0] crit_now;

  for (genvar g = 0; g < 4; g++) begin : gen_relay
    trc_mode_e mode;
    trc_reaction_e react;
    logic signed [16:0] cmp_value;
    logic [1:0] decision;
    logic want;
    logic delayed;
    logic tick;
    logic [9:0] limit;
    logic [9:0] count_reg;

    assign mode = trc_mode_e'(relay_cfg_reg[g][CFG_MODE_LSB +: 3]);
    assign react = trc_reaction_e'(relay_cfg_reg[g][CFG_REACT_LSB +: 2]);
    assign cmp_value = (relay_cfg_reg[g][CFG_PEAK_BIT] && peak_active) ? 17'(peak_value)
                                                                       : 17'(meas_value);
    assign decision = trc_decide(mode, cmp_value, 17'(primary_threshold_reg[g]),
                                 17'(secondary_threshold_reg[g]),
                                 17'({6'h00, band_half_width_reg[g]}));
    // cause of a critical situation depends on mode
    assign crit_now[g] = (g < NUM_RELAYS) && RELAYS_FITTED[g]
                         && ((mode == TRC_BUS_COMMANDED) ? link_lost_reg : meas_out_of_range);
    // delays counted in seconds or minutes
    assign tick = relay_cfg_reg[g][CFG_UNIT_MIN_BIT] ? minute_tick_reg : step_tick_reg;
    assign limit = want ? turn_on_delay_reg[g] : turn_off_delay_reg[g];
    assign delayed = ~crit_now[g] && (mode != TRC_BUS_COMMANDED) && decision[1]
                     && (mode != TRC_RELAY_DISABLED) && (mode <= TRC_BUS_COMMANDED);

    always_comb begin
      want = state_reg[g];
      if (crit_now[g]) begin
        unique case (react)
          TRC_FORCE_ON: want = 1'b1;
          TRC_FORCE_OFF: want = 1'b0;
          default: want = state_reg[g];
        endcase
      end else if (mode == TRC_BUS_COMMANDED) begin
        want = bus_cmd_reg[g];
      end else if (decision[1]) begin
        // disabled decides off, band keeps state
        want = decision[0];
      end
      state_next[g] = want;
      if (delayed && want != state_reg[g] && count_reg < limit) begin
        // crossing shorter than delay keeps state
        state_next[g] = state_reg[g];
      end
      if (!((g < NUM_RELAYS) && RELAYS_FITTED[g])) begin
        state_next[g] = 1'b0;
      end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        count_reg <= 10'h000;
      end else if (!delayed || want == state_reg[g] || state_next[g] != state_reg[g]) begin
        // timer restarts when value returns inside
        count_reg <= 10'h000;
      end else if (tick && count_reg != 10'h3ff) begin
        // count delay in tenths of unit
        count_reg <= count_reg + 10'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs and buzzer
  // ----------------------------------------------------------------
  logic sys_crit_reg;
  logic buzz_set;

  // critical or enabled relay activation sounds
  assign buzz_set = (buzzer_settings_reg[BUZ_ALARM_BIT]
                     && (meas_out_of_range | link_lost_reg) && !sys_crit_reg)
                    || |(state_next & ~state_reg & buzzer_settings_reg[BUZ_RELAY_LSB +: 4]);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= 4'h0;
      relay_out <= 4'h0;
      led_out <= 4'h0;
      crit_reg <= 4'h0;
      sys_crit_reg <= 1'b0;
      buzzer_reg <= 1'b0;
      buzzer_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      relay_out <= state_next;
      led_out <= state_next;
      crit_reg <= crit_now;
      sys_crit_reg <= meas_out_of_range | link_lost_reg;
      // button silences; a new event wins
      if (buzz_set) begin
        buzzer_reg <= 1'b1;
        buzzer_out <= 1'b1;
      end else if (button_press) begin
        buzzer_reg <= 1'b0;
        buzzer_out <= 1'b0;
      end
    end
  end

endmodule

/* File: sim/trc_load_model.sv */
// Behavioural relay coils, lamps and horn at the controller outputs
`timescale 1ns/100ps
module trc_load_model (
  // Drive from the controller
  input wire logic clk_sys,
  input wire logic [3:0] relay_out,
  input wire logic [3:0] led_out,
  input wire logic buzzer_out,
  // Observed load state
  output logic [3:0] coil_closed,
  output logic horn_on
);
  // coil counts closed only with its lamp lit
  always_ff @(posedge clk_sys) begin
    coil_closed <= relay_out & led_out;
    horn_on <= buzzer_out;
  end
endmodule

/* File: sim/trc_checker.sv */
// Port assertions of the threshold relay controller
`timescale 1ns/100ps
module trc_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Outputs
  input wire logic [3:0] relay_out,
  input wire logic [3:0] led_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
  property p_led; led_out == relay_out; endproperty
  a_led: assert property (p_led) else $error("lamp differs from relay");
  property p_fresh; $fell(rst) |-> relay_out == 4'h0; endproperty
  a_fresh: assert property (p_fresh) else $error("relay on after reset");
  property p_b_ans; s_wr_take |=> s_axi_bvalid; endproperty
  a_b_ans: assert property (p_b_ans) else $error("write response late");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_b_end; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready; endproperty
  a_b_end: assert property (p_b_end) else $error("write not reopened");
  property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_aw_block: assert property (p_aw_block) else $error("write taken during response");
  property p_r_ans; s_rd_take |=> s_axi_rvalid; endproperty
  a_r_ans: assert property (p_r_ans) else $error("read data late");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken during data");
endmodule
bind trc_top trc_checker chk (.*);

/* File: sim/testbench.sv */
// Self-checking bench of the threshold relay controller
`timescale 1ns/100ps
module testbench;
  import trc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, b;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, link_relay_data = 4'h0, relay_out, led_out, coil_closed;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic signed [15:0] meas_value = 16'sh0, peak_value = 16'sh0;
  logic peak_active = 1'b0, meas_out_of_range = 1'b0, link_frame_strobe = 1'b0;
  logic link_relay_we = 1'b0, button_press = 1'b0, buzzer_out, horn_on;
  int n_errors = 0, num_checks = 0, k;
  int mv[6] = '{0, 200, 400, 105, 200, 0};
  logic [3:0] ev[6] = '{4'ha, 4'h5, 4'h9, 4'h1, 4'h5, 4'ha};
  logic [3:0] em[6] = '{4'hf, 4'hf, 4'hf, 4'h3, 4'hf, 4'hf};
  always #25 clk_sys = ~clk_sys;
  // Short delay step keeps the delay tests brief
  trc_top #(.STEP_CYCLES(10)) dut (.*);
  trc_load_model load (.clk_sys(clk_sys), .relay_out(relay_out), .led_out(led_out),
    .buzzer_out(buzzer_out), .coil_closed(coil_closed), .horn_on(horn_on));
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task lost;
    n_errors++;
    $display("[FAIL] %0t no bus answer", $time);
    close_out;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (i == 40) lost;
    chk(s_axi_bresp, r);
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (i == 40) lost;
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, r);
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    wr(8'h8c, 32'h1, RESP_SLVERR);
    rd(8'h8c, 32'h0, RESP_SLVERR);
    $display("test reset and map done");
    // Relay 2 holds its thresholds swapped; relays 0 and 1 get an unused far one
    for (k = 0; k < 4; k++) begin
      b = 8'(32 * k);
      wr(b + OFS_PRIMARY, (k == 2) ? 300 : 100, RESP_OKAY);
      wr(b + OFS_SECONDARY, (k == 2) ? 100 : ((k == 3) ? 300 : 9000), RESP_OKAY);
      wr(b + OFS_HALF_WIDTH, 32'ha, RESP_OKAY);
      wr(b + OFS_RELAY_CFG, k + 1, RESP_OKAY);
      rd(b + OFS_RELAY_CFG, k + 1, RESP_OKAY);
    end
    for (k = 0; k < 6; k++) begin
      meas_value <= 16'(mv[k]);
      repeat (3) @(posedge clk_sys);
      chk(coil_closed & em[k], ev[k]);
    end
    $display("test threshold modes done");
    wr(OFS_DELAYS, 32'h3, RESP_OKAY);
    meas_value <= 16'sd200;
    repeat (15) @(posedge clk_sys);
    meas_value <= 16'sd0;
    repeat (5) @(posedge clk_sys);
    chk(relay_out[0], 1'b0);
    meas_value <= 16'sd200;
    repeat (25) @(posedge clk_sys);
    chk(relay_out[0], 1'b0);
    repeat (20) @(posedge clk_sys);
    chk(relay_out[0], 1'b1);
    $display("test delays done");
    meas_value <= 16'sd0;
    wr(OFS_RELAY_CFG, 32'h10, RESP_OKAY);
    wr(RELAY_STRIDE + OFS_RELAY_CFG, 32'h22, RESP_OKAY);
    wr(ADDR_BUZZER, 32'h1, RESP_OKAY);
    meas_out_of_range <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(relay_out[1:0], 2'b01);
    chk(horn_on, 1'b1);
    button_press <= 1'b1;
    @(posedge clk_sys);
    button_press <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(horn_on, 1'b0);
    meas_out_of_range <= 1'b0;
    $display("test critical done");
    wr(8'h40 + OFS_RELAY_CFG, 32'h5, RESP_OKAY);
    link_relay_data <= 4'h4;
    link_relay_we <= 1'b1;
    @(posedge clk_sys);
    link_relay_we <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(relay_out[2], 1'b1);
    wr(ADDR_LINK_TIMEOUT, 32'h2, RESP_OKAY);
    rd(ADDR_STATUS, 32'h43e, RESP_OKAY);
    link_frame_strobe <= 1'b1;
    @(posedge clk_sys);
    link_frame_strobe <= 1'b0;
    @(posedge clk_sys);
    rd(ADDR_STATUS, 32'h1e, RESP_OKAY);
    $display("test bus command and link done");
    close_out;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    lost;
  end
endmodule
